// ===== hw/sdis_regs.svh
`ifndef SDIS_REGS_SVH
`define SDIS_REGS_SVH
// ----------------------------------------------------------------
// Register map, word index times four gives the byte address
// ----------------------------------------------------------------
`define SDIS_IDX_CLAMP    8'h0f
`define SDIS_IDX_OUTMODE  8'h10
`define SDIS_IDX_STATUS   8'h11
`define SDIS_IDX_OVERRIDE 8'h12
// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SDIS_RST_CLAMP    8'h10
`define SDIS_RST_OUTMODE  8'h34
`define SDIS_RST_OVERRIDE 8'h00
// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define SDIS_B_EXT_CLAMP  5
`define SDIS_B_CLAMP_POL  4
`define SDIS_B_EXT_CLK    3
`define SDIS_B_OUTPUT_CLOCK_INVERT      7
`define SDIS_B_PIXSEL     6
`define SDIS_B_DRV_HI     5
`define SDIS_B_DRV_LO     4
`define SDIS_B_HIZ        3
`define SDIS_B_SDPOL      2
`define SDIS_B_IF_OVR     7
`define SDIS_B_IF_SEL     6
`define SDIS_B_HS_OVR     5
`define SDIS_B_HS_SEL     4
`define SDIS_B_VS_OVR     3
`define SDIS_B_VS_SEL     2
// ----------------------------------------------------------------
// Presence timeout in device clock cycles
// ----------------------------------------------------------------
`define SDIS_TIMEOUT_CYC  32'd100000
`endif

// ===== hw/sdis_pkg.sv
`default_nettype none
// ----------------------------------------------------------------
// Types
// ----------------------------------------------------------------
package sdis_pkg;
  // Output drive strength
  typedef enum logic [1:0] {SDIS_DRV_LOW, SDIS_DRV_MED, SDIS_DRV_HIGH} sdis_drive_t;
  // Bus slave state
  typedef enum logic {SDIS_IDLE, SDIS_ACK} sdis_bus_t;
endpackage
`default_nettype wire

// ===== hw/sdis_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "sdis_regs.svh"
module sdis_top
  import sdis_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `SDIS_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        srst_in,
  // Wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [31:0] wb_dat_in,
  input  wire logic [3:0]  wb_sel_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  output logic             wb_err_out,
  // Activity inputs
  input  wire logic        ana_hsync_in,
  input  wire logic        sog_in,
  input  wire logic        ana_vsync_in,
  input  wire logic        dig_clk_in,
  input  wire logic        ext_clamp_in,
  input  wire logic        hsync_clamp_in,
  // Clamp and clock controls
  output logic             clamp_active_out,
  output logic [2:0]       clamp_midscale_out,
  output logic             external_clock_select_out,
  output logic             pll_enable_out,
  // Output formatting
  output logic             output_clock_invert_out,
  output logic             two_pixel_mode_out,
  output sdis_drive_t      drive_strength_out,
  output logic             output_enable_out,
  output logic             output_high_impedance_out,
  output logic             sync_detect_pin_out,
  // Selected sources
  output logic             active_interface_out,
  output logic             active_hsync_out,
  output logic             active_vsync_out
);

  // ----------------------------------------------------------------
  // Presence detection
  // ----------------------------------------------------------------
  logic [3:0]  act_in;                 // Activity inputs as a vector
  logic [3:0]  prev_r, prev_nxt;       // Last sampled levels
  logic [3:0]  pres_r, pres_nxt;       // Presence flags: hs, sog, vs, dclk
  logic [31:0] cnt_r [4];              // Idle counters
  logic [31:0] cnt_nxt [4];

  assign act_in = {ana_hsync_in, sog_in, ana_vsync_in, dig_clk_in};

  // Edge restarts the counter, timeout clears the flag
  always_comb begin
    prev_nxt = act_in;
    pres_nxt = pres_r;
    for (int i = 0; i < 4; i++) begin
      cnt_nxt[i] = cnt_r[i];
      if (act_in[i] != prev_r[i]) begin
        cnt_nxt[i]  = 32'h0;
        pres_nxt[i] = 1'b1;
      end else if (cnt_r[i] >= TIMEOUT_CYC - 1) begin
        pres_nxt[i] = 1'b0;
      end else begin
        cnt_nxt[i] = cnt_r[i] + 32'h1;
      end
    end
  end

  // Register presence state
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      prev_r <= act_in;  // Pin level, so an idle-high pin gives no false edge
      pres_r <= 4'h0;
      for (int i = 0; i < 4; i++) cnt_r[i] <= 32'h0;
    end else begin
      prev_r <= prev_nxt;
      pres_r <= pres_nxt;
      for (int i = 0; i < 4; i++) cnt_r[i] <= cnt_nxt[i];
    end
  end

  // Named views of the flags
  logic hs_det, sog_det, vs_det, dclk_det, ana_det;
  assign hs_det   = pres_r[3];
  assign sog_det  = pres_r[2];
  assign vs_det   = pres_r[1];
  assign dclk_det = pres_r[0];
  // Analog side counts as live on a line sync only: Hsync pin or sync-on-green
  assign ana_det  = hs_det | sog_det;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] clamp_r, clamp_nxt;      // Clamp and clock source
  logic [7:0] outm_r, outm_nxt;        // Output mode
  logic [7:0] ovr_r, ovr_nxt;          // Source override
  sdis_bus_t  bus_r, bus_nxt;          // Bus state
  logic [31:0] rdat_r, rdat_nxt;       // Read data
  logic       err_r, err_nxt;          // Error answer
  logic [5:0] idx;                     // Word index
  logic       req;                     // New request
  logic       hit;                     // Mapped address
  logic [7:0] status;                  // Status byte

  assign idx = wb_adr_in[7:2];
  assign req = wb_cyc_in & wb_stb_in & (bus_r == SDIS_IDLE);
  assign hit = (idx == 6'(`SDIS_IDX_CLAMP)) | (idx == 6'(`SDIS_IDX_OUTMODE)) |
               (idx == 6'(`SDIS_IDX_STATUS)) | (idx == 6'(`SDIS_IDX_OVERRIDE));

  // ----------------------------------------------------------------
  // Source selection
  // ----------------------------------------------------------------
  logic ai_r, ai_nxt;                  // Active interface status
  logic ahs_r, ahs_nxt;                // Active Hsync status
  logic avs_r, avs_nxt;                // Active Vsync status

  // Automatic choice: lone source wins, both lets select apply (Vsync pin wins over sync-on-green), none holds
  always_comb begin
    ai_nxt  = ai_r;
    ahs_nxt = ahs_r;
    avs_nxt = avs_r;
    if (ovr_r[`SDIS_B_IF_OVR]) begin
      ai_nxt = ovr_r[`SDIS_B_IF_SEL];
    end else if (ana_det && dclk_det) begin
      ai_nxt = ovr_r[`SDIS_B_IF_SEL];
    end else if (dclk_det) begin
      ai_nxt = 1'b1;
    end else if (ana_det) begin
      ai_nxt = 1'b0;
    end
    if (ovr_r[`SDIS_B_HS_OVR]) begin
      ahs_nxt = ovr_r[`SDIS_B_HS_SEL];
    end else if (hs_det && sog_det) begin
      ahs_nxt = ovr_r[`SDIS_B_HS_SEL];
    end else if (sog_det) begin
      ahs_nxt = 1'b1;
    end else if (hs_det) begin
      ahs_nxt = 1'b0;
    end
    if (ovr_r[`SDIS_B_VS_OVR]) begin
      avs_nxt = ovr_r[`SDIS_B_VS_SEL];
    end else if (vs_det) begin
      avs_nxt = 1'b0;
    end else if (sog_det) begin
      avs_nxt = 1'b1;
    end
  end

  // Status byte, bit 0 reads zero
  assign status = {pres_r, ai_r, ahs_r, avs_r, 1'b0};

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  // One wait free cycle: ack one edge after the request, then idle
  always_comb begin
    clamp_nxt = clamp_r;
    outm_nxt  = outm_r;
    ovr_nxt   = ovr_r;
    bus_nxt   = SDIS_IDLE;
    rdat_nxt  = rdat_r;
    err_nxt   = 1'b0;
    if (req) begin
      bus_nxt = SDIS_ACK;
      err_nxt = ~hit;
      if (wb_we_in && wb_sel_in[0]) begin
        if (idx == 6'(`SDIS_IDX_CLAMP))    clamp_nxt = wb_dat_in[7:0];
        if (idx == 6'(`SDIS_IDX_OUTMODE))  outm_nxt  = {wb_dat_in[7:2], 2'b00};
        if (idx == 6'(`SDIS_IDX_OVERRIDE)) ovr_nxt   = wb_dat_in[7:0];
      end
      unique case (idx)
        6'(`SDIS_IDX_CLAMP):    rdat_nxt = {24'h0, clamp_r};
        6'(`SDIS_IDX_OUTMODE):  rdat_nxt = {24'h0, outm_r};
        6'(`SDIS_IDX_STATUS):   rdat_nxt = {24'h0, status};
        6'(`SDIS_IDX_OVERRIDE): rdat_nxt = {24'h0, ovr_r};
        default:                rdat_nxt = 32'h0;
      endcase
    end
  end

  // Register bus, control and selection state
  always_ff @(posedge clock_in) begin
    if (srst_in) begin
      clamp_r <= `SDIS_RST_CLAMP;
      outm_r  <= `SDIS_RST_OUTMODE;
      ovr_r   <= `SDIS_RST_OVERRIDE;
      bus_r   <= SDIS_IDLE;
      rdat_r  <= 32'h0;
      err_r   <= 1'b0;
      ai_r    <= 1'b0;
      ahs_r   <= 1'b0;
      avs_r   <= 1'b0;
    end else begin
      clamp_r <= clamp_nxt;
      outm_r  <= outm_nxt;
      ovr_r   <= ovr_nxt;
      bus_r   <= bus_nxt;
      rdat_r  <= rdat_nxt;
      err_r   <= err_nxt;
      ai_r    <= ai_nxt;
      ahs_r   <= ahs_nxt;
      avs_r   <= avs_nxt;
    end
  end

  assign wb_ack_out = (bus_r == SDIS_ACK) & ~err_r;
  assign wb_err_out = (bus_r == SDIS_ACK) & err_r;
  assign wb_dat_out = rdat_r;

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  logic clamp_act;                     // Clamp level in effect
  always_comb begin
    if (clamp_r[`SDIS_B_EXT_CLAMP]) begin
      clamp_act = clamp_r[`SDIS_B_CLAMP_POL] ? ext_clamp_in : ~ext_clamp_in;
    end else begin
      clamp_act = hsync_clamp_in;
    end
  end
  assign clamp_active_out          = clamp_act;
  assign clamp_midscale_out        = clamp_r[2:0];
  assign external_clock_select_out = clamp_r[`SDIS_B_EXT_CLK];
  assign pll_enable_out            = ~clamp_r[`SDIS_B_EXT_CLK];
  assign output_clock_invert_out   = outm_r[`SDIS_B_OUTPUT_CLOCK_INVERT] & ai_r;
  assign two_pixel_mode_out        = outm_r[`SDIS_B_PIXSEL] & ai_r;
  assign drive_strength_out        = outm_r[`SDIS_B_DRV_HI] ? SDIS_DRV_HIGH :
                                     (outm_r[`SDIS_B_DRV_LO] ? SDIS_DRV_MED : SDIS_DRV_LOW);
  assign output_high_impedance_out = outm_r[`SDIS_B_HIZ];
  assign output_enable_out         = ~outm_r[`SDIS_B_HIZ];
  assign sync_detect_pin_out       = outm_r[`SDIS_B_SDPOL] ? (ai_r ? dclk_det : ana_det) :
                                     ~(ai_r ? dclk_det : ana_det);
  assign active_interface_out      = ai_r;
  assign active_hsync_out          = ahs_r;
  assign active_vsync_out          = avs_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Source selection: overrides, shared selects, lone sources
  a_iface_override: assert property (@(posedge clock_in) disable iff (srst_in)
    ovr_r[`SDIS_B_IF_OVR] |=> ai_r == $past(ovr_r[`SDIS_B_IF_SEL]))
    else $error("interface override ignored");
  a_hs_override: assert property (@(posedge clock_in) disable iff (srst_in)
    ovr_r[`SDIS_B_HS_OVR] |=> ahs_r == $past(ovr_r[`SDIS_B_HS_SEL]))
    else $error("hsync override ignored");
  a_vs_override: assert property (@(posedge clock_in) disable iff (srst_in)
    ovr_r[`SDIS_B_VS_OVR] |=> avs_r == $past(ovr_r[`SDIS_B_VS_SEL]))
    else $error("vsync override ignored");
  a_lone_digital: assert property (@(posedge clock_in) disable iff (srst_in)
    (!ovr_r[`SDIS_B_IF_OVR] && dclk_det && !ana_det) |=> ai_r)
    else $error("lone digital not chosen");
  a_lone_analog: assert property (@(posedge clock_in) disable iff (srst_in)
    (!ovr_r[`SDIS_B_IF_OVR] && ana_det && !dclk_det) |=> !ai_r)
    else $error("lone analog not chosen");
  a_iface_hold: assert property (@(posedge clock_in) disable iff (srst_in)
    (!ovr_r[`SDIS_B_IF_OVR] && !ana_det && !dclk_det) |=> ai_r == $past(ai_r))
    else $error("interface not held");
  a_both_iface: assert property (@(posedge clock_in) disable iff (srst_in)
    (ana_det && dclk_det) |=> ai_r == $past(ovr_r[`SDIS_B_IF_SEL]))
    else $error("interface select not applied");
  a_both_hsync: assert property (@(posedge clock_in) disable iff (srst_in)
    (!ovr_r[`SDIS_B_HS_OVR] && hs_det && sog_det) |=> ahs_r == $past(ovr_r[`SDIS_B_HS_SEL]))
    else $error("hsync select not applied");
  a_hs_lone_sog: assert property (@(posedge clock_in) disable iff (srst_in)
    (!ovr_r[`SDIS_B_HS_OVR] && sog_det && !hs_det) |=> ahs_r)
    else $error("lone green hsync not chosen");
  a_hs_lone_pin: assert property (@(posedge clock_in) disable iff (srst_in)
    (!ovr_r[`SDIS_B_HS_OVR] && hs_det && !sog_det) |=> !ahs_r)
    else $error("lone pin hsync not chosen");
  a_vs_pin_first: assert property (@(posedge clock_in) disable iff (srst_in)
    (!ovr_r[`SDIS_B_VS_OVR] && vs_det) |=> !avs_r)
    else $error("vsync pin not preferred");
  a_vs_lone_sog: assert property (@(posedge clock_in) disable iff (srst_in)
    (!ovr_r[`SDIS_B_VS_OVR] && !vs_det && sog_det) |=> avs_r)
    else $error("lone green vsync not chosen");

  // Presence flags and status
  a_presence_set: assert property (@(posedge clock_in) disable iff (srst_in)
    (act_in[0] != prev_r[0]) |=> dclk_det)
    else $error("clock presence not set");
  a_hs_detect: assert property (@(posedge clock_in) disable iff (srst_in)
    (act_in[3] != prev_r[3]) |=> hs_det)
    else $error("hsync presence not set");
  a_presence_clear: assert property (@(posedge clock_in) disable iff (srst_in)
    (act_in[3] == prev_r[3] && cnt_r[3] >= TIMEOUT_CYC - 1) |=> !hs_det)
    else $error("hsync presence not cleared");
  a_status_byte: assert property (@(posedge clock_in) disable iff (srst_in)
    (req && !wb_we_in && idx == 6'(`SDIS_IDX_STATUS)) |=> wb_dat_out[7:1] == $past(status[7:1]))
    else $error("status read wrong");

  // Output formatting and clamp
  a_hiz_out: assert property (@(posedge clock_in) disable iff (srst_in)
    output_high_impedance_out != output_enable_out)
    else $error("hiz and enable disagree");
  a_drive_code: assert property (@(posedge clock_in) disable iff (srst_in)
    (outm_r[5:4] == 2'b01) |-> drive_strength_out == SDIS_DRV_MED)
    else $error("drive code wrong");
  a_output_clock_invert_analog: assert property (@(posedge clock_in) disable iff (srst_in)
    !active_interface_out |-> !output_clock_invert_out)
    else $error("clock invert on analog");
  a_pixel_analog: assert property (@(posedge clock_in) disable iff (srst_in)
    !active_interface_out |-> !two_pixel_mode_out)
    else $error("two pixel mode on analog");
  a_clamp_external: assert property (@(posedge clock_in) disable iff (srst_in)
    (clamp_r[`SDIS_B_EXT_CLAMP] && clamp_r[`SDIS_B_CLAMP_POL]) |-> clamp_active_out == ext_clamp_in)
    else $error("external clamp polarity wrong");

  // Register bus answers
  a_ack_pulse: assert property (@(posedge clock_in) disable iff (srst_in)
    wb_ack_out |=> !wb_ack_out)
    else $error("ack held too long");
  a_err_pulse: assert property (@(posedge clock_in) disable iff (srst_in)
    wb_err_out |=> !wb_err_out)
    else $error("err held too long");
  a_bus_answer: assert property (@(posedge clock_in) disable iff (srst_in)
    req |=> (wb_ack_out || wb_err_out))
    else $error("request not answered");

endmodule
`default_nettype wire

// ===== tb/sdis_video_src.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Video source model
// ----------------------------------------------------------------
module sdis_video_src (
  // Clock
  input  wire logic       clock_in,
  // Line enables: hsync, sog, vsync, digital clock
  input  wire logic [3:0] run_in,
  // Activity lines in the same order
  output logic      [3:0] lines_out
);
  logic [1:0] cnt_r;  // Toggle pacing
  initial begin
    cnt_r = 2'h0;
    lines_out = 4'h0;
  end
  // Running lines toggle every fourth cycle; stopped ones hold level
  always @(posedge clock_in) begin
    cnt_r <= cnt_r + 2'h1;
    if (cnt_r == 2'h0) begin
      lines_out <= lines_out ^ run_in;
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb_sync_detect_interface_select.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------
// Register bank testbench
// ----------------------------------------------------------------
module tb_sync_detect_interface_select;
  import sdis_pkg::*;
  logic        clock_in, srst_in, cyc, stb, we, ack, err, e;  // Bus
  logic        ext_clamp, hs_clamp, clamp_act, ecs, pll_en;    // Clamp
  logic        output_clock_invert, two_pix, oen, hiz, sdpin, ai, active_hsync_status, active_vsync_status; // Outputs
  logic [7:0]  adr;                                           // Address
  logic [31:0] wdat, rdat, q;                                 // Data
  logic [3:0]  sel, sel_v, run, lines;                        // Misc
  logic [2:0]  mid;                                           // Midscale
  sdis_drive_t drv;                                           // Drive
  int          n_fail, samples_checked;                       // Counters
  sdis_top #(.TIMEOUT_CYC(16)) DUT (
    .clock_in(clock_in), .srst_in(srst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_dat_in(wdat), .wb_sel_in(sel),
    .wb_dat_out(rdat), .wb_ack_out(ack), .wb_err_out(err),
    .ana_hsync_in(lines[3]), .sog_in(lines[2]), .ana_vsync_in(lines[1]),
    .dig_clk_in(lines[0]), .ext_clamp_in(ext_clamp), .hsync_clamp_in(hs_clamp),
    .clamp_active_out(clamp_act), .clamp_midscale_out(mid),
    .external_clock_select_out(ecs), .pll_enable_out(pll_en),
    .output_clock_invert_out(output_clock_invert), .two_pixel_mode_out(two_pix),
    .drive_strength_out(drv), .output_enable_out(oen),
    .output_high_impedance_out(hiz), .sync_detect_pin_out(sdpin),
    .active_interface_out(ai), .active_hsync_out(active_hsync_status), .active_vsync_out(active_vsync_status));
  sdis_video_src src (.clock_in(clock_in), .run_in(run), .lines_out(lines));
  // Clock
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, x, s);
    end
  endtask
  // Verdict
  task automatic test_done();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // One classic cycle; holds until ack or err is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clock_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= sel_v;
    wdat <= {24'h0, d};
    do begin
      @(posedge clock_in);
      n++;
    end while (!(ack === 1'b1 || err === 1'b1) && n < 50);
    if (n >= 50) chk("bus answer", 1'b0, 1'b1);
    q = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  // Register shorthands
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    wb(1'b0, a, 8'h00);
    chk("register read", q, {24'h0, x});
  endtask
  // Long enough for a stale flag to time out and a live one to set
  task automatic settle();
    repeat (40) @(posedge clock_in);
  endtask
  // Watchdog
  initial begin
    repeat (20000) @(posedge clock_in);
    n_fail++;
    test_done();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {srst_in, cyc, stb, we, ext_clamp, hs_clamp} = 6'h20;
    {adr, wdat, sel, run} = '0;
    sel_v = 4'h1;
    n_fail = 0;
    samples_checked = 0;
    repeat (8) @(posedge clock_in);
    srst_in <= 1'b0;
    rd(8'h3c, 8'h10);
    rd(8'h40, 8'h34);
    rd(8'h48, 8'h00);
    rd(8'h44, 8'h00);
    chk("drive", 32'(drv), 32'(SDIS_DRV_HIGH));
    chk("sync pin", sdpin, 1'b0);
    chk("pll", {ecs, pll_en}, 2'b01);
    // Unmapped read, read-only and byte-disabled writes
    wb(1'b0, 8'h00, 8'h00);
    chk("bus error", e, 1'b1);
    wr(8'h44, 8'hff);
    rd(8'h44, 8'h00);
    sel_v = 4'he;
    wr(8'h3c, 8'h2f);
    sel_v = 4'h1;
    rd(8'h3c, 8'h10);
    // Clamp and clock source
    wr(8'h3c, 8'h2f);
    ext_clamp <= 1'b1;
    @(posedge clock_in);
    chk("clamp", clamp_act, 1'b0);
    chk("midscale", mid, 3'h7);
    chk("pll", {ecs, pll_en}, 2'b10);
    wr(8'h3c, 8'h35);
    chk("clamp", clamp_act, 1'b1);
    chk("midscale", mid, 3'h5);
    wr(8'h3c, 8'h10);
    ext_clamp <= 1'b0;
    hs_clamp <= 1'b1;
    @(posedge clock_in);
    chk("clamp", clamp_act, 1'b1);
    // Every drive code
    for (int i = 0; i < 4; i++) begin
      wr(8'h40, 8'(i << 4));
      chk("drive", 32'(drv), (i == 0) ? 32'(SDIS_DRV_LOW) : (i == 1) ? 32'(SDIS_DRV_MED) : 32'(SDIS_DRV_HIGH));
    end
    wr(8'h40, 8'h08);
    chk("high z", {hiz, oen}, 2'b10);
    // Digital clock alone
    wr(8'h40, 8'hc4);
    run <= 4'h1;
    settle();
    rd(8'h44, 8'h18);
    chk("format", {output_clock_invert, two_pix, ai}, 3'b111);
    chk("sync pin", sdpin, 1'b1);
    wr(8'h40, 8'hc0);
    chk("sync pin", sdpin, 1'b0);
    // Analog pins alone, digital flag times out
    run <= 4'ha;
    settle();
    rd(8'h44, 8'ha0);
    chk("format", {output_clock_invert, two_pix, ai, active_hsync_status, active_vsync_status}, 5'h00);
    chk("sync pin", sdpin, 1'b0);
    // Sync-on-green alone
    run <= 4'h4;
    settle();
    rd(8'h44, 8'h46);
    // Both interfaces and both hsyncs: software selects apply
    run <= 4'hd;
    wr(8'h48, 8'h50);
    settle();
    chk("auto select", {ai, active_hsync_status}, 2'b11);
    wr(8'h48, 8'h00);
    repeat (2) @(posedge clock_in);
    chk("auto select", {ai, active_hsync_status}, 2'b00);
    // Overrides against a lone pin hsync
    run <= 4'h8;
    settle();
    wr(8'h48, 8'hfc);
    repeat (2) @(posedge clock_in);
    rd(8'h48, 8'hfc);
    chk("override", {ai, active_hsync_status, active_vsync_status}, 3'b111);
    rd(8'h44, 8'h8e);
    wr(8'h48, 8'ha8);
    repeat (2) @(posedge clock_in);
    chk("override", {ai, active_hsync_status, active_vsync_status}, 3'b000);
    // Nothing detected: selection held
    wr(8'h48, 8'h00);
    run <= 4'h1;
    settle();
    run <= 4'h0;
    settle();
    rd(8'h44, 8'h08);
    // Mid-run reset returns registers and selections to defaults
    srst_in <= 1'b1;
    repeat (2) @(posedge clock_in);
    srst_in <= 1'b0;
    rd(8'h40, 8'h34);
    rd(8'h44, 8'h00);
    test_done();
  end
endmodule
`default_nettype wire
